// file: src/reset_and_code_protect_unit.sv
// Reset sequencer, reset cause flags and program memory protection
// Function
// RQ1: Code protect blocks external memory access
// RQ2: Core fetches and reads never blocked
// RQ3: Write-protect field sizes refused self-write region
// RQ4: ID words only in program/verify mode
// RQ5: Accept power-on, brown-out, watchdog, clear resets
// RQ6: Retained registers cleared only on power-on
// RQ7: Watchdog in sleep wakes, no register reset
// RQ8: Update reset cause flags per source
// RQ9: Filter glitches on clear pin
// RQ10: Watchdog reset never drives clear pin
// RQ11: Clear pin enable selects external reset
// RQ12: Brown-out enable gates brown-out reset
// RQ13: Brown-out only after 100 us low
// RQ14: Hold reset until supply good, then timer
// RQ15: Brown-out during timer restarts full delay
// RQ16: Timer config bit is active low
// RQ17: Power-up timer counts 64 ms, parameter
// RQ18: Brown-out ignored when disabled or asleep
// RQ19: Missed watchdog clear resets and flags
// RQ20: Run only after timers and pin release
// RQ21: No timer when disabled; pin release runs
// RQ22: Reset cause register at index 8Eh
// RQ23: Power-on flag reads 0, software sets it
// RQ24: Sources merged, released on clock edge
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
module reset_and_code_protect_unit
  import rcp_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_CYCLES = POWERUP_TIMER_CYC,
  parameter int unsigned BOR_CYCLES = BOR_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitor
  input wire logic poweron_detect,
  input wire logic below_brownout_threshold,
  // Clear pin, never driven
  input wire logic master_clear_n_in,
  output logic master_clear_n_out,
  output logic master_clear_n_oe,
  // Configuration word
  input wire logic code_protect_n,
  input wire logic [1:0] self_write_protect_sel,
  input wire logic ext_clear_pin_enable,
  input wire logic brownout_enable,
  input wire logic powerup_timer_disable_n,
  // Core and watchdog
  input wire logic sleeping,
  input wire logic sleep_enter,
  input wire logic watchdog_clear_instruction,
  input wire logic watchdog_timeout,
  output logic core_reset_n,
  output logic retained_reset_n,
  output logic core_wake,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  // Program memory access
  input wire logic prog_verify_mode,
  input wire logic ext_rd_req,
  input wire logic ext_wr_req,
  input wire logic [PADDR_W-1:0] ext_addr,
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic ext_wr_allow,
  output logic ext_rd_allow,
  output logic [WORD_W-1:0] ext_rdata,
  input wire logic [PADDR_W-1:0] core_rd_addr,
  output logic core_rd_allow,
  input wire logic self_wr_req,
  input wire logic [PADDR_W-1:0] self_wr_addr,
  output logic self_wr_allow,
  output logic self_wr_refused
);
  typedef struct packed {
    seq_t state;
    logic [TMR_W-1:0] tmr;
    logic [BORC_W-1:0] borc;
    logic powerup_timer_armed;
    logic por_flag;
    logic bor_flag;
    logic to_n;
    logic pd_n;
    logic core_rst_n;
    logic ret_rst_n;
    logic wake;
    logic pdet_seen;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [WORD_W-1:0] ext_rdata;
    logic wr_refused;
  } unit_st_t;

  unit_st_t st_q;
  unit_st_t st_d;
  clear_pin_if cp_if ();

  logic brownout_event;
  logic clear_low;
  logic wdt_reset;
  logic wdt_wake;
  logic clr_reset;
  logic prog_range;
  logic id_range;
  logic ext_ok;
  logic [PADDR_W-1:0] wp_top;
  logic wp_hit;
  logic apb_setup;
  logic apb_commit;
  logic hit_cause;
  logic hit_status;
  logic [31:0] rd_val;

  assign cp_if.pin_raw = master_clear_n_in;
  assign cp_if.enable = ext_clear_pin_enable; // [RQ11]
  assign clear_low = cp_if.clean_low;

  clear_pin_filter u_clear_pin_filter (
    .pclk(pclk),
    .presetn(presetn),
    .cp(cp_if.filter)
  );

  // Reset source decode
  assign brownout_event = (st_q.borc == BORC_W'(BOR_CYCLES - 1)) && below_brownout_threshold; // [RQ13]
  assign wdt_reset = watchdog_timeout && !sleeping && (st_q.state == S_RUN); // [RQ19]
  assign wdt_wake = watchdog_timeout && sleeping && (st_q.state == S_RUN); // [RQ7]
  assign clr_reset = clear_low && (st_q.state == S_RUN); // [RQ5]

  // Memory protection
  assign prog_range = (ext_addr <= PROG_TOP);
  assign id_range = (ext_addr >= ID_FIRST) && (ext_addr <= ID_LAST);
  assign ext_ok = prog_verify_mode && ((prog_range && code_protect_n) || id_range); // [RQ1] [RQ4]
  assign ext_wr_allow = ext_wr_req && ext_ok;
  assign ext_rd_allow = ext_rd_req && ext_ok;
  assign core_rd_allow = (core_rd_addr <= PROG_TOP); // [RQ2] [RQ4]

  always_comb begin
    if (self_write_protect_sel == WP_SEL_256) begin
      wp_top = WP_TOP_256;
    end else if (self_write_protect_sel == WP_SEL_512) begin
      wp_top = WP_TOP_512;
    end else begin
      wp_top = WP_TOP_1K;
    end
  end
  assign wp_hit = (self_write_protect_sel != WP_NONE) && (self_wr_addr <= wp_top); // [RQ3]
  assign self_wr_allow = self_wr_req && !wp_hit && (self_wr_addr <= PROG_TOP);

  // APB decode
  assign apb_setup = psel && penable && !st_q.ready;
  assign apb_commit = psel && penable && st_q.ready;
  assign hit_cause = (paddr == ADDR_RESET_CAUSE); // [RQ22]
  assign hit_status = (paddr == ADDR_SEQ_STATUS);

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_cause) begin
      rd_val[POR_BIT] = st_q.por_flag;
      rd_val[BOR_BIT] = st_q.bor_flag;
    end else if (hit_status) begin
      rd_val[2:0] = st_q.state;
      rd_val[3] = st_q.pd_n;
      rd_val[4] = st_q.to_n;
      rd_val[5] = st_q.powerup_timer_armed;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.wake = 1'b0;
    st_d.wr_refused = self_wr_req && wp_hit; // [RQ3]
    st_d.pdet_seen = poweron_detect;

    // Bus side: one wait cycle, data from flip-flops
    st_d.ready = apb_setup;
    if (apb_setup) begin
      st_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
      st_d.slverr = !(hit_cause || hit_status) || (pwrite && hit_status);
    end else begin
      st_d.slverr = 1'b0;
    end
    if (apb_commit && pwrite && hit_cause) begin
      st_d.por_flag = pwdata[POR_BIT]; // [RQ23]
      st_d.bor_flag = pwdata[BOR_BIT];
    end

    // Read data gated by protection
    if (ext_rd_req) begin
      st_d.ext_rdata = ext_ok ? mem_rdata : '0; // [RQ1]
    end

    // Core status flag events from the core
    if (watchdog_clear_instruction) begin
      st_d.to_n = 1'b1;
      st_d.pd_n = 1'b1;
    end
    if (sleep_enter) begin
      st_d.to_n = 1'b1;
      st_d.pd_n = 1'b0;
    end

    // Brown-out qualification counter
    if (below_brownout_threshold && brownout_enable && !sleeping) begin // [RQ12] [RQ18]
      if (st_q.borc != BORC_W'(BOR_CYCLES - 1)) begin
        st_d.borc = st_q.borc + BORC_W'(1);
      end
    end else begin
      st_d.borc = '0;
    end

    // Sequencer
    st_d.core_rst_n = 1'b0;
    st_d.ret_rst_n = 1'b1;
    case (st_q.state)
      S_POR: begin
        st_d.ret_rst_n = 1'b0; // [RQ6]
        st_d.tmr = '0;
        if (!poweron_detect) begin
          st_d.state = S_SUPPLY;
        end
      end
      S_SUPPLY: begin
        st_d.tmr = '0;
        if (!below_brownout_threshold || !brownout_enable) begin // [RQ14]
          if (st_q.powerup_timer_armed && !powerup_timer_disable_n) begin // [RQ16]
            st_d.state = S_POWERUP_TIMER;
          end else begin
            st_d.state = S_OST; // [RQ21]
          end
        end
      end
      S_POWERUP_TIMER: begin
        if (st_q.tmr == TMR_W'(POWERUP_TIMER_CYCLES - 1)) begin // [RQ17]
          st_d.tmr = '0;
          st_d.state = S_OST;
        end else begin
          st_d.tmr = st_q.tmr + TMR_W'(1);
        end
      end
      S_OST: begin
        if (st_q.tmr == TMR_W'(OST_CYC - 1)) begin
          st_d.tmr = '0;
          st_d.state = S_PIN;
        end else begin
          st_d.tmr = st_q.tmr + TMR_W'(1);
        end
      end
      S_PIN: begin
        if (!clear_low) begin // [RQ20]
          st_d.state = S_RUN;
          st_d.powerup_timer_armed = 1'b0;
          st_d.core_rst_n = 1'b1;
        end
      end
      S_RUN: begin
        st_d.core_rst_n = 1'b1;
        if (wdt_reset) begin
          st_d.to_n = 1'b0; // [RQ8] [RQ19]
          st_d.state = S_SUPPLY;
          st_d.core_rst_n = 1'b0;
        end else if (wdt_wake) begin
          st_d.to_n = 1'b0; // [RQ7] [RQ8]
          st_d.pd_n = 1'b0;
          st_d.wake = 1'b1;
        end else if (clr_reset) begin
          if (sleeping) begin
            st_d.to_n = 1'b1; // [RQ8]
            st_d.pd_n = 1'b0;
          end
          st_d.state = S_PIN;
          st_d.core_rst_n = 1'b0;
        end
      end
      default: begin
        st_d.state = S_POR;
      end
    endcase

    // Brown-out wins over everything but power-on
    if (brownout_event && (st_q.state != S_POR)) begin
      st_d.state = S_SUPPLY; // [RQ15]
      st_d.tmr = '0;
      st_d.powerup_timer_armed = 1'b1;
      st_d.bor_flag = 1'b0; // [RQ8]
      st_d.to_n = 1'b1;
      st_d.pd_n = 1'b1;
      st_d.core_rst_n = 1'b0;
      st_d.wake = 1'b0;
    end

    // Power-on detector, synchronised, highest priority
    if (st_q.pdet_seen) begin // [RQ24] [RQ18]
      st_d.state = S_POR;
      st_d.tmr = '0;
      st_d.powerup_timer_armed = 1'b1;
      st_d.por_flag = 1'b0; // [RQ8] [RQ23]
      st_d.to_n = 1'b1;
      st_d.pd_n = 1'b1;
      st_d.core_rst_n = 1'b0;
      st_d.ret_rst_n = 1'b0;
      st_d.wake = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{state: S_POR, tmr: '0, borc: '0, powerup_timer_armed: 1'b1, por_flag: CAUSE_RESET[POR_BIT],
                bor_flag: CAUSE_RESET[BOR_BIT], to_n: 1'b1, pd_n: 1'b1, core_rst_n: 1'b0,
                ret_rst_n: 1'b0, wake: 1'b0, pdet_seen: 1'b0, ready: 1'b0,
                slverr: 1'b0, rdata: 32'h0000_0000, ext_rdata: '0, wr_refused: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slverr && st_q.ready;
  assign master_clear_n_out = 1'b0;
  assign master_clear_n_oe = 1'b0; // [RQ10]
  assign core_reset_n = st_q.core_rst_n;
  assign retained_reset_n = st_q.ret_rst_n;
  assign core_wake = st_q.wake;
  assign timeout_flag_n = st_q.to_n;
  assign powerdown_flag_n = st_q.pd_n;
  assign ext_rdata = st_q.ext_rdata;
  assign self_wr_refused = st_q.wr_refused;
endmodule : reset_and_code_protect_unit

// file: src/rcp_pkg.sv
// Constants, register map and types shared by the reset and protection unit
package rcp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_MHZ = 250;

  // Timing figures and derived cycle counts
  localparam int unsigned BOR_TIME_NS = 100000;
  localparam int unsigned BOR_CYC = (BOR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_TIMER_TIME_US = 64000;
  localparam int unsigned POWERUP_TIMER_CYC = POWERUP_TIMER_TIME_US * CLK_MHZ;
  localparam int unsigned CLR_FILT_NS = 200;
  localparam int unsigned CLR_FILT_CYC = (CLR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OST_CYC = 1024;
  localparam int unsigned TMR_W = 24;
  localparam int unsigned BORC_W = 16;
  localparam int unsigned FILT_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESET_CAUSE = 8'h8E;
  localparam logic [7:0] IDX_SEQ_STATUS = 8'h8F;
  localparam logic [31:0] ADDR_RESET_CAUSE = {22'h000000, IDX_RESET_CAUSE, 2'h0};
  localparam logic [31:0] ADDR_SEQ_STATUS = {22'h000000, IDX_SEQ_STATUS, 2'h0};

  // Field positions of the reset cause register
  localparam int unsigned POR_BIT = 1;
  localparam int unsigned BOR_BIT = 0;
  localparam logic [1:0] CAUSE_RESET = 2'h0;

  // Program memory map
  localparam int unsigned PADDR_W = 14;
  localparam logic [13:0] PROG_TOP = 14'h0FFF;
  localparam logic [13:0] ID_FIRST = 14'h2000;
  localparam logic [13:0] ID_LAST = 14'h2003;
  localparam logic [13:0] WP_TOP_256 = 14'h00FF;
  localparam logic [13:0] WP_TOP_512 = 14'h01FF;
  localparam logic [13:0] WP_TOP_1K = 14'h03FF;
  localparam logic [1:0] WP_NONE = 2'h3;
  localparam logic [1:0] WP_SEL_256 = 2'h2;
  localparam logic [1:0] WP_SEL_512 = 2'h1;
  localparam int unsigned WORD_W = 14;

  typedef enum logic [2:0] {
    S_POR = 3'b000,
    S_SUPPLY = 3'b001,
    S_POWERUP_TIMER = 3'b010,
    S_OST = 3'b011,
    S_PIN = 3'b100,
    S_RUN = 3'b101
  } seq_t;
endpackage : rcp_pkg

// file: src/clear_pin_if.sv
// Carrier between the clear pin filter and the sequencer
`timescale 1ns/1ns
interface clear_pin_if;
  logic pin_raw;
  logic enable;
  logic clean_low;
  modport filter (input pin_raw, input enable, output clean_low);
  modport user (output pin_raw, output enable, input clean_low);
endinterface : clear_pin_if

// file: src/clear_pin_filter.sv
// Synchroniser and glitch filter for the external clear pin
`timescale 1ns/1ns
module clear_pin_filter
  import rcp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  clear_pin_if.filter cp
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic low;
    logic [FILT_W-1:0] cnt;
  } filt_st_t;

  filt_st_t st_q;
  filt_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = cp.pin_raw;
    st_d.s2 = st_q.s1;
    // Output flips only after the new level holds for the whole window; clearing enable clears it at once
    if (!cp.enable) begin
      st_d.low = 1'b0;
      st_d.cnt = '0;
    end else if ((!st_q.s2) == st_q.low) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == FILT_W'(CLR_FILT_CYC - 1)) begin
      st_d.low = !st_q.s2; // [RQ9]
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, low: 1'b0, cnt: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cp.clean_low = st_q.low;
endmodule : clear_pin_filter

// file: tb/rcp_props.sv
// Concurrent checks on the ports of the reset and protection unit
`timescale 1ns/1ns
module rcp_props
  import rcp_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_CYCLES = 20,
  parameter int unsigned BOR_CYCLES = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic poweron_detect,
  input wire logic master_clear_n_in,
  input wire logic master_clear_n_oe,
  input wire logic code_protect_n,
  input wire logic [1:0] self_write_protect_sel,
  input wire logic sleeping,
  input wire logic watchdog_timeout,
  input wire logic core_reset_n,
  input wire logic core_wake,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n,
  input wire logic prog_verify_mode,
  input wire logic ext_rd_req,
  input wire logic ext_wr_req,
  input wire logic [PADDR_W-1:0] ext_addr,
  input wire logic ext_wr_allow,
  input wire logic ext_rd_allow,
  input wire logic [WORD_W-1:0] ext_rdata,
  input wire logic [PADDR_W-1:0] core_rd_addr,
  input wire logic core_rd_allow,
  input wire logic self_wr_req,
  input wire logic [PADDR_W-1:0] self_wr_addr,
  input wire logic self_wr_allow,
  input wire logic self_wr_refused
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pin_undriven: assert property (!master_clear_n_oe)
    else $error("clear pin driven");
  chk_core_fetch: assert property (core_rd_addr <= PROG_TOP |-> core_rd_allow)
    else $error("core read blocked");
  chk_cp_write: assert property (!code_protect_n && ext_wr_req && ext_addr <= PROG_TOP |-> !ext_wr_allow)
    else $error("protected write let through");
  chk_cp_zero: assert property (!code_protect_n && ext_rd_req && ext_addr <= PROG_TOP |=> ext_rdata == '0)
    else $error("protected read not zero");
  chk_id_hidden: assert property (!prog_verify_mode |-> !ext_rd_allow && !ext_wr_allow)
    else $error("external access outside verify mode");
  chk_wp_refuse: assert property (self_wr_req && self_write_protect_sel == 2'h0 && self_wr_addr <= WP_TOP_1K
    |-> !self_wr_allow ##1 self_wr_refused) else $error("self write not refused");
  chk_wdt_wake: assert property (watchdog_timeout && sleeping && core_reset_n && !poweron_detect
    |=> core_wake && core_reset_n && !timeout_flag_n && !powerdown_flag_n) else $error("bad watchdog wake");
  chk_wdt_reset: assert property (watchdog_timeout && !sleeping && core_reset_n && !poweron_detect
    |=> !core_reset_n && !timeout_flag_n) else $error("bad watchdog reset");
  chk_glitch_ignored: assert property (core_reset_n && $fell(master_clear_n_in) ##1 master_clear_n_in[*8]
    |-> core_reset_n) else $error("glitch reset the core");

  cover property (core_wake);
  cover property ($fell(core_reset_n) && !timeout_flag_n);
  cover property (self_wr_refused);
endmodule : rcp_props

// file: tb/supply_model.sv
// Supply monitor and clear pin model, commanded by the bench
`timescale 1ns/1ns
module supply_model (
  input wire logic pclk,
  output logic poweron_detect,
  output logic below_brownout_threshold,
  output logic master_clear_n_in
);
  initial begin
    poweron_detect = 1'h1;
    below_brownout_threshold = 1'h1;
    master_clear_n_in = 1'h1; // Weak pull-up level
  end
  task automatic power_up();
    poweron_detect <= 1'h0;
    repeat (8) @(posedge pclk);
    below_brownout_threshold <= 1'h0;
  endtask : power_up
  task automatic dip(input int n);
    below_brownout_threshold <= 1'h1;
    repeat (n) @(posedge pclk);
    below_brownout_threshold <= 1'h0;
  endtask : dip
  task automatic pin_low(input int n);
    master_clear_n_in <= 1'h0;
    repeat (n) @(posedge pclk);
    master_clear_n_in <= 1'h1;
  endtask : pin_low
endmodule : supply_model

// file: tb/test_reset_and_code_protect_unit.sv
// Self-checking bench for the reset and protection unit
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h", $time, a); end end
module test_reset_and_code_protect_unit;
  import rcp_pkg::*;
  localparam int unsigned PW = 200;
  localparam int unsigned BC = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic poweron_detect, below_brownout_threshold, master_clear_n_in, master_clear_n_out, master_clear_n_oe;
  logic code_protect_n, ext_clear_pin_enable, brownout_enable, powerup_timer_disable_n;
  logic [1:0] self_write_protect_sel;
  logic sleeping, sleep_enter, watchdog_clear_instruction, watchdog_timeout;
  logic core_reset_n, retained_reset_n, core_wake, timeout_flag_n, powerdown_flag_n;
  logic prog_verify_mode, ext_rd_req, ext_wr_req, ext_wr_allow, ext_rd_allow, core_rd_allow;
  logic self_wr_req, self_wr_allow, self_wr_refused;
  logic [13:0] ext_addr, mem_rdata, ext_rdata, core_rd_addr, self_wr_addr;
  int errors, checked, cyc, n;

  reset_and_code_protect_unit #(.POWERUP_TIMER_CYCLES(PW), .BOR_CYCLES(BC)) u_reset_and_code_protect_unit (.*);
  supply_model u_supply_model (.*);

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // No cycle limit; ends on pready or at the bench timeout
    do begin @(posedge pclk); end while (pready !== 1'h1);
    rd = prdata; e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_run();
    n = 0;
    while (core_reset_n !== 1'h1 && n < 5000) begin @(posedge pclk); n++; end
  endtask : wait_run
  task automatic t_power_on();
    `CHK(retained_reset_n, 1'h0)
    u_supply_model.power_up();
    wait_run();
    `CHK(n >= PW + OST_CYC && n < PW + OST_CYC + 20, 1'h1)
    `CHK({retained_reset_n, timeout_flag_n, powerdown_flag_n}, 3'h7)
    apb(1'h0, ADDR_RESET_CAUSE, '0);
    `CHK(rd, 32'h0)
    apb(1'h1, ADDR_RESET_CAUSE, 32'h3);
    apb(1'h0, ADDR_RESET_CAUSE, '0);
    `CHK(rd, 32'h3)
    apb(1'h0, 32'h100, '0);
    `CHK({e, rd}, {1'h1, 32'h0})
    apb(1'h0, ADDR_SEQ_STATUS, '0);
    `CHK(rd, {26'h0, 1'h0, 1'h1, 1'h1, S_RUN})
    apb(1'h1, ADDR_SEQ_STATUS, '0);
    `CHK({e, rd}, {1'h1, 32'h0})
  endtask : t_power_on
  task automatic t_brownout();
    u_supply_model.dip(BC - 3);
    repeat (4) @(posedge pclk);
    `CHK(core_reset_n, 1'h1)
    brownout_enable <= 1'h0;
    u_supply_model.dip(BC * 4);
    `CHK(core_reset_n, 1'h1)
    brownout_enable <= 1'h1; sleeping <= 1'h1;
    @(posedge pclk);
    u_supply_model.dip(BC * 4);
    `CHK(core_reset_n, 1'h1)
    sleeping <= 1'h0;
    @(posedge pclk);
    u_supply_model.dip(BC + 4);
    `CHK(core_reset_n, 1'h0)
    repeat (50) @(posedge pclk);
    u_supply_model.dip(BC + 4);
    wait_run();
    `CHK(n >= PW + OST_CYC, 1'h1)
    apb(1'h0, ADDR_RESET_CAUSE, '0);
    `CHK(rd, 32'h2)
    powerup_timer_disable_n <= 1'h1;
    u_supply_model.dip(BC + 4);
    wait_run();
    `CHK(n >= OST_CYC && n < OST_CYC + 20, 1'h1)
    powerup_timer_disable_n <= 1'h0;
  endtask : t_brownout
  task automatic t_watchdog();
    watchdog_timeout <= 1'h1;
    @(posedge pclk);
    watchdog_timeout <= 1'h0;
    repeat (2) @(posedge pclk);
    `CHK({core_reset_n, timeout_flag_n, master_clear_n_oe, master_clear_n_out}, 4'h0)
    wait_run();
    `CHK(n < PW + OST_CYC, 1'h1)
  endtask : t_watchdog
  task automatic t_wake();
    sleep_enter <= 1'h1; sleeping <= 1'h1;
    @(posedge pclk);
    sleep_enter <= 1'h0; watchdog_timeout <= 1'h1;
    @(posedge pclk);
    watchdog_timeout <= 1'h0;
    n = 0;
    repeat (4) begin @(posedge pclk); if (core_wake === 1'h1) n++; end
    `CHK({n[1:0], core_reset_n, timeout_flag_n, powerdown_flag_n}, 5'h0C)
    sleeping <= 1'h0; watchdog_clear_instruction <= 1'h1;
    @(posedge pclk);
    watchdog_clear_instruction <= 1'h0;
    repeat (2) @(posedge pclk);
    `CHK({timeout_flag_n, powerdown_flag_n}, 2'h3)
  endtask : t_wake
  task automatic t_clear_pin();
    u_supply_model.pin_low(1);
    repeat (60) @(posedge pclk);
    `CHK(core_reset_n, 1'h1)
    ext_clear_pin_enable <= 1'h0;
    u_supply_model.pin_low(100);
    `CHK(core_reset_n, 1'h1)
    ext_clear_pin_enable <= 1'h1; sleeping <= 1'h1;
    @(posedge pclk);
    u_supply_model.pin_low(100);
    `CHK({core_reset_n, timeout_flag_n, powerdown_flag_n}, 3'h2)
    sleeping <= 1'h0;
    wait_run();
    u_supply_model.pin_low(PW + OST_CYC + 100);
    wait_run();
    `CHK({n <= CLR_FILT_CYC + 10, timeout_flag_n, powerdown_flag_n}, 3'h6)
  endtask : t_clear_pin
  task automatic t_protect();
    logic [13:0] tops [4];
    tops = '{WP_TOP_1K, WP_TOP_512, WP_TOP_256, PROG_TOP};
    prog_verify_mode <= 1'h1; code_protect_n <= 1'h0; ext_rd_req <= 1'h1; ext_wr_req <= 1'h1;
    ext_addr <= 14'h0010; mem_rdata <= 14'h1ABC; core_rd_addr <= PROG_TOP;
    repeat (2) @(posedge pclk);
    `CHK({ext_wr_allow, ext_rd_allow, ext_rdata, core_rd_allow}, 17'h1)
    code_protect_n <= 1'h1;
    repeat (2) @(posedge pclk);
    `CHK({ext_rd_allow, ext_rdata}, 15'h5ABC)
    ext_addr <= ID_LAST; code_protect_n <= 1'h0;
    repeat (2) @(posedge pclk);
    `CHK({ext_rd_allow, ext_wr_allow}, 2'h3)
    prog_verify_mode <= 1'h0;
    repeat (2) @(posedge pclk);
    `CHK({ext_rd_allow, ext_wr_allow}, 2'h0)
    ext_rd_req <= 1'h0; ext_wr_req <= 1'h0; self_wr_req <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      self_write_protect_sel <= s[1:0]; self_wr_addr <= tops[s];
      @(posedge pclk);
      self_wr_addr <= tops[s] + 14'h1;
      @(posedge pclk);
      `CHK({self_wr_allow, self_wr_refused}, {s != 3 || 1'h0, s != 3})
    end
    self_wr_req <= 1'h0;
  endtask : t_protect

  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = '0; pwdata = '0;
    code_protect_n = 1'h1; self_write_protect_sel = WP_NONE; ext_clear_pin_enable = 1'h1;
    brownout_enable = 1'h1; powerup_timer_disable_n = 1'h0; sleeping = 1'h0; sleep_enter = 1'h0;
    watchdog_clear_instruction = 1'h0; watchdog_timeout = 1'h0; prog_verify_mode = 1'h0;
    ext_rd_req = 1'h0; ext_wr_req = 1'h0; ext_addr = '0; mem_rdata = '0; core_rd_addr = '0;
    self_wr_req = 1'h0; self_wr_addr = '0; errors = 0; checked = 0; cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_power_on();
    t_brownout();
    t_watchdog();
    t_wake();
    t_clear_pin();
    t_protect();
    summarize();
  end
endmodule : test_reset_and_code_protect_unit
bind reset_and_code_protect_unit rcp_props #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES), .BOR_CYCLES(BOR_CYCLES)) u_rcp_props (.*);
